/* File: pkg/extbus_defines.svh */
/*
 Timing counts and configuration positions for the external bus strobes.
 Assumes inclusion by bare name from the design file and the testbench.
*/
`ifndef EXTBUS_DEFINES_SVH
`define EXTBUS_DEFINES_SVH
`define CLK_PERIOD_NS      50
`define ADDR_PHASE_NS      50
`define ADDR_PHASE_CYC     ((`ADDR_PHASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DATA_PHASE_NS      150
`define DATA_PHASE_CYC     ((`DATA_PHASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CFG_A_WIDTH_BIT    1
`define CFG_B_WIDTH_BIT    2
`define CFG_RST            8'h00
`define ADDR_RST           16'h0000
`endif

/* File: pkg/extbus_pkg.sv */
/*
 Types for the external bus strobe block.
 Assumes the defines header is available on the include path.
*/
package extbus_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} bus_state_t;
endpackage

/* File: verilog/external_bus_strobes.sv */
/*
 External bus cycle sequencer: multiplexed address/data lines, the
 start-of-cycle pulse or address-valid level on one shared strobe pin,
 bus width selection, byte enables and input pin sampling.
 Assumes a core that raises a one-cycle request and holds its inputs
 steady while busy is high; an external latch captures the address.
*/
`timescale 1ns/100ps
`default_nettype none
`include "extbus_defines.svh"
module external_bus_strobes
	import extbus_pkg::*;
(
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	input  wire logic        REQ_I,
	input  wire logic        EXT_I,
	input  wire logic        WRITE_I,
	input  wire logic [15:0] ADDR_I,
	input  wire logic [15:0] WDATA_I,
	input  wire logic        WORD_I,
	input  wire logic [7:0]  CHIP_CONFIG_REG_A_I,
	input  wire logic [7:0]  CHIP_CONFIG_REG_B_I,
	input  wire logic        STROBE_LEVEL_MODE_I,
	input  wire logic        POWERDOWN_I,
	input  wire logic        BUS_WIDTH_SELECT_I,
	input  wire logic        EXT_IRQ_IN_I,
	input  wire logic [15:0] AD_I,
	output logic      [15:0] AD_O,
	output logic      [15:0] AD_OE_O,
	output logic             STROBE_O,
	output logic             HIGH_BYTE_ENABLE_N_O,
	output logic             BUSY_O,
	output logic             DONE_O,
	output logic      [15:0] RDATA_O,
	output logic             EXT_IRQ_O
);
	bus_state_t  state_r, state_nxt;
	logic [15:0] ad_r, ad_nxt, oe_r, oe_nxt, rdata_r, rdata_nxt;
	logic        strobe_r, strobe_nxt, bhe_n_r, bhe_n_nxt;
	logic        done_r, done_nxt, wide_r, wide_nxt, wr_r, wr_nxt;
	logic        lvl_r, lvl_nxt, irq_r, irq_nxt, irq_d_r, irq_d_nxt;
	logic [1:0]  cnt_r, cnt_nxt;
	logic [15:0] wdat_r, wdat_nxt;
	logic        addr0_r, addr0_nxt, word_r, word_nxt;
	logic        busy_r, busy_nxt;
	logic [15:0] ad_s1_r, ad_s2_r;
	logic        bw_s1_r, bw_s2_r, irq_s1_r, irq_s2_r;

	// Width decode from the two configuration bits and the pin.
	function automatic logic width16(input logic a, input logic b,
		input logic pin);
		width16 = (a && b) ? pin : a;
	endfunction

	// Two-flop synchronisers on every pin input; reset is the only level.
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ad_s1_r  <= 16'h0000;
			ad_s2_r  <= 16'h0000;
			bw_s1_r  <= 1'b0;
			bw_s2_r  <= 1'b0;
			irq_s1_r <= 1'b0;
			irq_s2_r <= 1'b0;
		end else begin
			ad_s1_r  <= AD_I;
			ad_s2_r  <= ad_s1_r;
			bw_s1_r  <= BUS_WIDTH_SELECT_I;
			bw_s2_r  <= bw_s1_r;
			irq_s1_r <= EXT_IRQ_IN_I;
			irq_s2_r <= irq_s1_r;
		end
	end

	always_comb begin
		state_nxt = state_r;
		ad_nxt    = ad_r;
		oe_nxt    = oe_r;
		rdata_nxt = rdata_r;
		strobe_nxt = strobe_r;
		bhe_n_nxt = bhe_n_r;
		done_nxt  = 1'b0;
		wide_nxt  = wide_r;
		wr_nxt    = wr_r;
		lvl_nxt   = lvl_r;
		cnt_nxt   = cnt_r;
		wdat_nxt  = wdat_r;
		addr0_nxt = addr0_r;
		word_nxt  = word_r;
		irq_d_nxt = irq_s2_r;
		// Powerdown has no clean edge to rely on, so the level wakes.
		if (POWERDOWN_I)
			irq_nxt = irq_s2_r;
		else
			irq_nxt = irq_s2_r && !irq_d_r;
		case (state_r)
		ST_IDLE: begin
			// The strobe idles in its inactive sense for the chosen mode.
			strobe_nxt = STROBE_LEVEL_MODE_I;
			oe_nxt = 16'h0000;
			bhe_n_nxt = 1'b1;
			if (REQ_I && EXT_I) begin
				state_nxt = ST_ADDR;
				lvl_nxt   = STROBE_LEVEL_MODE_I;
				strobe_nxt = !STROBE_LEVEL_MODE_I;
				ad_nxt    = ADDR_I;
				oe_nxt    = 16'hffff;
				wr_nxt    = WRITE_I;
				wdat_nxt  = WDATA_I;
				addr0_nxt = ADDR_I[0];
				word_nxt  = WORD_I;
				wide_nxt  = width16(
					CHIP_CONFIG_REG_A_I[`CFG_A_WIDTH_BIT],
					CHIP_CONFIG_REG_B_I[`CFG_B_WIDTH_BIT], bw_s2_r);
				// Byte lanes: both, high only or low only.
				bhe_n_nxt = !(width16(
					CHIP_CONFIG_REG_A_I[`CFG_A_WIDTH_BIT],
					CHIP_CONFIG_REG_B_I[`CFG_B_WIDTH_BIT], bw_s2_r)
					&& (WORD_I || ADDR_I[0]));
				cnt_nxt = 2'(`ADDR_PHASE_CYC - 1);
			end
		end
		ST_ADDR: begin
			if (cnt_r != 2'h0) begin
				cnt_nxt = cnt_r - 2'h1;
			end else begin
				state_nxt = ST_DATA;
				// Pulse ends here; the level form stays low to the end.
				strobe_nxt = 1'b0;
				ad_nxt = wr_r ? wdat_r : 16'h0000;
				oe_nxt = wr_r ? (wide_r ? 16'hffff : 16'h00ff) : 16'h0000;
				cnt_nxt = 2'(`DATA_PHASE_CYC - 1);
			end
		end
		ST_DATA: begin
			if (cnt_r != 2'h0) begin
				cnt_nxt = cnt_r - 2'h1;
			end else begin
				state_nxt = ST_IDLE;
				strobe_nxt = lvl_r;
				oe_nxt = 16'h0000;
				bhe_n_nxt = 1'b1;
				done_nxt = 1'b1;
				if (!wr_r)
					rdata_nxt = wide_r ? ad_s2_r
						: {8'h00, ad_s2_r[7:0]};
			end
		end
		default: state_nxt = ST_IDLE;
		endcase
		busy_nxt = (state_nxt != ST_IDLE);
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_r <= ST_IDLE;
			ad_r    <= `ADDR_RST;
			oe_r    <= 16'h0000;
			rdata_r <= 16'h0000;
			strobe_r <= 1'b0;
			bhe_n_r <= 1'b1;
			done_r  <= 1'b0;
			wide_r  <= 1'b0;
			wr_r    <= 1'b0;
			lvl_r   <= 1'b0;
			cnt_r   <= 2'h0;
			wdat_r  <= 16'h0000;
			addr0_r <= 1'b0;
			word_r  <= 1'b0;
			irq_r   <= 1'b0;
			irq_d_r <= 1'b0;
			busy_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ad_r    <= ad_nxt;
			oe_r    <= oe_nxt;
			rdata_r <= rdata_nxt;
			strobe_r <= strobe_nxt;
			bhe_n_r <= bhe_n_nxt;
			done_r  <= done_nxt;
			wide_r  <= wide_nxt;
			wr_r    <= wr_nxt;
			lvl_r   <= lvl_nxt;
			cnt_r   <= cnt_nxt;
			wdat_r  <= wdat_nxt;
			addr0_r <= addr0_nxt;
			word_r  <= word_nxt;
			irq_r   <= irq_nxt;
			irq_d_r <= irq_d_nxt;
			busy_r  <= busy_nxt;
		end
	end

	assign AD_O    = ad_r;
	assign AD_OE_O = oe_r;
	assign STROBE_O = strobe_r;
	assign HIGH_BYTE_ENABLE_N_O = bhe_n_r;
	assign BUSY_O  = busy_r;
	assign DONE_O  = done_r;
	assign RDATA_O = rdata_r;
	assign EXT_IRQ_O = irq_r;

	AST_ADDR_DRIVEN: assert property (@(posedge CLK_I) disable iff (RST_I)
		state_r == ST_IDLE && REQ_I && EXT_I |=> AD_O == $past(ADDR_I)
		&& AD_OE_O == 16'hffff) else $error("address not driven");
	AST_WRITE_DATA: assert property (@(posedge CLK_I) disable iff (RST_I)
		$rose(state_r == ST_DATA) && wr_r |-> AD_O == wdat_r)
		else $error("write data not driven");
	AST_NO_INTERNAL: assert property (@(posedge CLK_I) disable iff (RST_I)
		state_r == ST_IDLE && !(REQ_I && EXT_I) |=> state_r == ST_IDLE)
		else $error("cycle started for internal access");
	AST_LEVEL_HOLD: assert property (@(posedge CLK_I) disable iff (RST_I)
		state_r != ST_IDLE && lvl_r |-> !STROBE_O)
		else $error("level strobe high during cycle");
	AST_LEVEL_END: assert property (@(posedge CLK_I) disable iff (RST_I)
		DONE_O && lvl_r |-> STROBE_O)
		else $error("level strobe not released");
	AST_PULSE_START: assert property (@(posedge CLK_I) disable iff (RST_I)
		$rose(state_r == ST_ADDR) && !lvl_r |-> STROBE_O)
		else $error("latch pulse missing");
	AST_PULSE_END: assert property (@(posedge CLK_I) disable iff (RST_I)
		state_r == ST_DATA |-> !STROBE_O)
		else $error("latch pulse held into data");
	AST_BYTE_ENC: assert property (@(posedge CLK_I) disable iff (RST_I)
		state_r != ST_IDLE && !wide_r |-> HIGH_BYTE_ENABLE_N_O)
		else $error("high byte enabled on 8-bit bus");
	AST_BYTE_LANES: assert property (@(posedge CLK_I) disable iff (RST_I)
		state_r != ST_IDLE && wide_r |-> HIGH_BYTE_ENABLE_N_O
		== !(word_r || addr0_r)) else $error("byte lanes wrong");
	AST_PD_LEVEL: assert property (@(posedge CLK_I) disable iff (RST_I)
		POWERDOWN_I && irq_s2_r |=> EXT_IRQ_O)
		else $error("powerdown level ignored");
	COV_READ: cover property (@(posedge CLK_I) DONE_O && !wr_r);
	COV_WRITE: cover property (@(posedge CLK_I) DONE_O && wr_r);
	COV_LEVEL: cover property (@(posedge CLK_I) DONE_O && lvl_r);
endmodule
`default_nettype wire

/* File: tb/mem_model.sv */
/* Address latch and memory model on the far side of the bus.
 Assumes its mode input matches the block's strobe mode. */
`timescale 1ns/100ps
`default_nettype none
module mem_model (
	input  wire logic        clk_i,
	input  wire logic [15:0] ad_i,
	input  wire logic [15:0] oe_i,
	input  wire logic        strobe_i,
	input  wire logic        level_i,
	output logic      [15:0] ad_o
);
	logic [15:0] addr_r = 16'h0000;
	logic [15:0] drv_r = 16'h0000;
	logic [2:0]  cnt_r = 3'h0;
	logic        act_d_r = 1'b0;
	logic        act;
	assign act  = (strobe_i != level_i);
	assign ad_o = drv_r;
	// Only the first active edge latches, so a level strobe held low
	// through a write data phase never takes write data for an address.
	always @(posedge clk_i) begin
		act_d_r <= act;
		if (oe_i == 16'hffff && act && !act_d_r) begin
			addr_r <= ad_i;
			cnt_r <= 3'h4;
		end else if (cnt_r != 3'h0)
			cnt_r <= cnt_r - 3'h1;
	end
	// Released lines toggle so stale data never passes for a read.
	always @(negedge clk_i)
		drv_r <= (cnt_r != 3'h0) ? (addr_r ^ 16'h5a5a) : ~drv_r;
endmodule
`default_nettype wire

/* File: tb/tb_external_bus_strobes.sv */
/* Self-checking bench for the external bus strobes.
 Assumes the memory model answers reads with the address xor 5a5a. */
`timescale 1ns/100ps
`default_nettype none
`include "extbus_defines.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	failures++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_external_bus_strobes;
	typedef struct packed {logic w, wd; logic [15:0] a;
		logic [1:0] cf; logic bw, lv, e16;} row_t;
	logic CLK_I = 1'b0, RST_I = 1'b1, REQ_I = 1'b0, EXT_I = 1'b1;
	logic WRITE_I = 1'b0, WORD_I = 1'b0, POWERDOWN_I = 1'b0;
	logic STROBE_LEVEL_MODE_I = 1'b0, BUS_WIDTH_SELECT_I = 1'b0;
	logic EXT_IRQ_IN_I = 1'b0, STROBE_O, HIGH_BYTE_ENABLE_N_O;
	logic BUSY_O, DONE_O, EXT_IRQ_O;
	logic [15:0] ADDR_I = 16'h0000, WDATA_I = 16'h0000, AD_I, AD_O;
	logic [15:0] AD_OE_O, RDATA_O, d;
	logic [7:0] cfa = 8'h00, cfb = 8'h00;
	logic [3:0] n;
	int failures = 0, check_count = 0, cycles = 0;
	row_t r;
	row_t rows [6] = '{
		'{1'b1, 1'b1, 16'h1234, 2'b10, 1'b0, 1'b0, 1'b1},
		'{1'b0, 1'b0, 16'h2345, 2'b10, 1'b0, 1'b1, 1'b1},
		'{1'b0, 1'b0, 16'h3456, 2'b01, 1'b1, 1'b0, 1'b0},
		'{1'b1, 1'b0, 16'h4568, 2'b11, 1'b1, 1'b1, 1'b1},
		'{1'b0, 1'b1, 16'h5678, 2'b11, 1'b0, 1'b0, 1'b0},
		'{1'b0, 1'b1, 16'hfffe, 2'b00, 1'b1, 1'b1, 1'b0}};
	external_bus_strobes uut (.CLK_I(CLK_I), .RST_I(RST_I),
		.REQ_I(REQ_I), .EXT_I(EXT_I), .WRITE_I(WRITE_I),
		.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WORD_I(WORD_I),
		.CHIP_CONFIG_REG_A_I(cfa), .CHIP_CONFIG_REG_B_I(cfb),
		.STROBE_LEVEL_MODE_I(STROBE_LEVEL_MODE_I),
		.POWERDOWN_I(POWERDOWN_I), .EXT_IRQ_IN_I(EXT_IRQ_IN_I),
		.BUS_WIDTH_SELECT_I(BUS_WIDTH_SELECT_I), .AD_I(AD_I),
		.AD_O(AD_O), .AD_OE_O(AD_OE_O), .STROBE_O(STROBE_O),
		.HIGH_BYTE_ENABLE_N_O(HIGH_BYTE_ENABLE_N_O), .BUSY_O(BUSY_O),
		.DONE_O(DONE_O), .RDATA_O(RDATA_O), .EXT_IRQ_O(EXT_IRQ_O));
	mem_model partner (.clk_i(CLK_I), .ad_i(AD_O), .oe_i(AD_OE_O),
		.strobe_i(STROBE_O), .level_i(STROBE_LEVEL_MODE_I),
		.ad_o(AD_I));
	always #25 CLK_I = ~CLK_I;
	always @(posedge CLK_I) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic pulse_req();
		REQ_I = 1'b1;
		@(negedge CLK_I);
		REQ_I = 1'b0;
	endtask
	initial begin
		repeat (10) @(negedge CLK_I);
		`CHK("rst_oe", 16'h0000, AD_OE_O)
		`CHK("rst_bhe", 1'b1, HIGH_BYTE_ENABLE_N_O)
		repeat (10) @(negedge CLK_I);
		RST_I = 1'b0;
		for (int i = 0; i < 6; i++) begin
			r = rows[i];
			{WRITE_I, WORD_I, ADDR_I, WDATA_I} = {r.w, r.wd, r.a, ~r.a};
			cfa = {6'h00, r.cf[1], 1'b0};
			cfb = {5'h00, r.cf[0], 2'b00};
			{BUS_WIDTH_SELECT_I, STROBE_LEVEL_MODE_I} = {r.bw, r.lv};
			repeat (4) @(negedge CLK_I);
			pulse_req();
			`CHK("addr", r.a, AD_O)
			`CHK("oe", 16'hffff, AD_OE_O)
			`CHK("strobe", ~r.lv, STROBE_O)
			@(negedge CLK_I);
			`CHK("strobe2", 1'b0, STROBE_O)
			if (r.w)
				`CHK("wd", ~r.a[7:0], AD_O[7:0])
			if (r.w && r.e16)
				`CHK("wdhi", ~r.a[15:8], AD_O[15:8])
			if (r.e16)
				`CHK("bhe", ~(r.wd | r.a[0]), HIGH_BYTE_ENABLE_N_O)
			else
				`CHK("bhe8", 1'b1, HIGH_BYTE_ENABLE_N_O)
			for (n = 0; n < 8 && DONE_O !== 1'b1; n++) @(negedge CLK_I);
			`CHK("done", 1'b1, DONE_O)
			`CHK("lat", 4'(`DATA_PHASE_CYC), n)
			`CHK("busy_end", 1'b0, BUSY_O)
			`CHK("idle", r.lv, STROBE_O)
			d = r.a ^ 16'h5a5a;
			if (!r.w)
				`CHK("rd", r.e16 ? d : {8'h00, d[7:0]}, RDATA_O)
		end
		ADDR_I = 16'h0abc;
		pulse_req();
		`CHK("b2b", 16'h0abc, AD_O)
		repeat (6) @(negedge CLK_I);
		EXT_I = 1'b0;
		pulse_req();
		repeat (3) begin
			`CHK("int", 1'b1, STROBE_O)
			`CHK("int_busy", 1'b0, BUSY_O)
			`CHK("int_oe", 16'h0000, AD_OE_O)
			@(negedge CLK_I);
		end
		EXT_IRQ_IN_I = 1'b1;
		n = 0;
		repeat (6) begin
			@(negedge CLK_I);
			n += EXT_IRQ_O;
		end
		`CHK("irq", 4'h1, n)
		POWERDOWN_I = 1'b1;
		repeat (4) @(negedge CLK_I);
		`CHK("pd", 1'b1, EXT_IRQ_O)
		POWERDOWN_I = 1'b0;
		EXT_I = 1'b1;
		pulse_req();
		RST_I = 1'b1;
		@(negedge CLK_I);
		`CHK("mid_busy", 1'b0, BUSY_O)
		`CHK("mid_oe", 16'h0000, AD_OE_O)
		RST_I = 1'b0;
		repeat (2) @(negedge CLK_I);
		`CHK("mid_idle", 1'b1, STROBE_O)
		ADDR_I = 16'h1357;
		pulse_req();
		for (n = 0; n < 8 && DONE_O !== 1'b1; n++) @(negedge CLK_I);
		`CHK("done2", 1'b1, DONE_O)
		d = 16'h1357 ^ 16'h5a5a;
		`CHK("rd2", {8'h00, d[7:0]}, RDATA_O)
		wrap_up();
	end
endmodule
`default_nettype wire
